/* hw/capture_pkg.sv */
// constants and register map of the pulse interval capture channel
// ====================================================================
// Overview of operation
// [RQ1] sixteen-bit counter times pulses on input pin
// [RQ2] firmware selects system clock divided by four
// [RQ3] firmware sets capture mode, rising edge valid
// [RQ4] valid input edge triggers capture when enabled
// [RQ5] start bit clears count and starts counting
// [RQ6] valid edge copies count into data register
// [RQ7] capture completion raises capture done interrupt
// [RQ8] after capture count restarts from zero
// [RQ9] firmware discards first capture after start
// [RQ10] handler stores later captures in RAM
// [RQ11] firmware takes eight measurements then halts
// [RQ12] seventeen-bit option stores thirty-two-bit entries; no such option here, counter and stored entries are sixteen bits
// [RQ13] start routine unmasks interrupt before starting
// [RQ14] overflowed interval recorded as zero by software
// [RQ15] valid sixteen-bit results span 0006H to FFFFH
// [RQ16] counter wraps FFFFH to zero, flags overflow
package capture_pkg;
    // ================================================================
    // widths
    localparam int COUNT_W = 16;                 // counter width
    localparam int ADDR_W  = 4;                  // register address width
    localparam int DATA_W  = 32;                 // register data width
    localparam int PRS_W   = 4;                  // prescaler select width
    // ================================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_START  = 4'h0; // start/stop, write
    localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h4; // mode and prescaler
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h8; // live count, read
    localparam logic [ADDR_W-1:0] OFS_DATA   = 4'hC; // capture data, read
    localparam logic [ADDR_W-1:0] OFS_STAT   = 4'h1; // status, read
    localparam logic [ADDR_W-1:0] OFS_CLR    = 4'h2; // status clear, write
    localparam logic [ADDR_W-1:0] OFS_IRQEN  = 4'h3; // irq enable
    // ================================================================
    // field positions
    localparam int START_BIT   = 0;  // start channel
    localparam int STOP_BIT    = 1;  // stop channel
    localparam int ACTIVE_BIT  = 2;  // status: running
    localparam int MODE_CAP    = 0;  // capture trigger enable
    localparam int MODE_EDGE   = 1;  // 1 rising, 0 falling edge
    localparam int MODE_PRS_LO = 4;  // prescaler select field base
    localparam int EV_CAP      = 0;  // event: capture done
    localparam int EV_OVF      = 1;  // event: counter overflow
    localparam int EV_W        = 2;  // number of events
    // ================================================================
    // reset values
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [7:0]         MODE_RST  = 8'h00;
    localparam logic [EV_W-1:0]    EV_RST    = 2'h0;
endpackage

/* hw/clock_prescaler.sv */
// operation clock enable generator: fclk divided by a power of two
`timescale 1ns/1ps
module clock_prescaler
    import capture_pkg::*;
#(
    parameter int DIV_W = 16                      // prescale counter width
) (
    input  wire logic             clk,            // system clock
    input  wire logic             rst_n,          // sync reset, active low
    input  wire logic             run,            // counting active
    input  wire logic [PRS_W-1:0] prs_sel,        // divide by 2**prs_sel
    output logic                  tick            // one-cycle operation clock
);
    logic [DIV_W-1:0] div_q;                      // free divider
    logic [DIV_W-1:0] div_d;                      // next divider
    logic [DIV_W-1:0] mask;                       // terminal mask

    // ================================================================
    // next value: restart on idle, count otherwise
    always_comb begin
        mask  = DIV_W'((32'h1 << prs_sel) - 32'h1);
        div_d = div_q;
        if (!run) begin
            div_d = '0;
        end else if ((div_q & mask) == mask) begin
            div_d = '0;
        end else begin
            div_d = div_q + DIV_W'(1);
        end
    end
    // tick at terminal count of the selected division
    assign tick = run && ((div_q & mask) == mask); // RQ2

    // register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end
endmodule // clock_prescaler

/* hw/pulse_interval_capture_channel.sv */
// capture channel: counts the operation clock, latches count on input edge
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module pulse_interval_capture_channel
    import capture_pkg::*;
(
    input  wire logic              clk,              // 50 MHz system clock
    input  wire logic              rst_n,            // sync reset, active low
    input  wire logic              pulse_input_pin,  // external pulse pin
    input  wire logic [ADDR_W-1:0] reg_addr,         // register address
    input  wire logic [DATA_W-1:0] reg_wdata,        // write data
    input  wire logic              reg_wr,           // write strobe
    input  wire logic              reg_rd,           // read strobe
    output logic      [DATA_W-1:0] reg_rdata,        // read data, next cycle
    output logic                   capture_done_irq  // level interrupt
);
    // ================================================================
    // declarations
    typedef enum logic {ST_IDLE, ST_RUN} chan_state_t; // channel states

    chan_state_t        state_q, state_d;          // channel state
    logic [COUNT_W-1:0] count_q, count_d;          // channel_count_value
    logic [COUNT_W-1:0] data_q, data_d;            // channel_capture_data
    logic [7:0]         mode_q, mode_d;            // mode register
    logic [EV_W-1:0]    stat_q, stat_d;            // sticky status
    logic [EV_W-1:0]    irqen_q, irqen_d;          // interrupt enable
    logic [DATA_W-1:0]  rdata_q, rdata_d;          // read data
    logic               sync1_q, sync2_q, prev_q;  // pin synchroniser
    logic               tick;                      // operation clock enable
    logic               edge_det;                  // valid edge seen
    logic               capture;                   // capture this cycle
    logic               wrap;                      // counter wrap
    logic               start_wr, stop_wr;         // start/stop writes
    logic [EV_W-1:0]    ev;                        // events this cycle

    // ================================================================
    // pin synchroniser: two flops, edge compare after the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pulse_input_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // rising or falling edge as selected
    assign edge_det = mode_q[MODE_EDGE] ? (sync2_q && !prev_q)
                                        : (!sync2_q && prev_q);

    // ================================================================
    // operation clock enable
    clock_prescaler #(
        .DIV_W   (16)
    ) u_prescaler (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (state_q == ST_RUN),
        .prs_sel (mode_q[MODE_PRS_LO +: PRS_W]),
        .tick    (tick)
    );

    // ================================================================
    // decode of control writes
    assign start_wr = reg_wr && (reg_addr == OFS_START) && reg_wdata[START_BIT];
    assign stop_wr  = reg_wr && (reg_addr == OFS_START) && reg_wdata[STOP_BIT];
    // capture only while running and trigger enabled
    assign capture  = (state_q == ST_RUN) && mode_q[MODE_CAP] && edge_det; // RQ4
    assign wrap     = (state_q == ST_RUN) && tick && (count_q == '1);
    assign ev[EV_CAP] = capture;                       // RQ7
    assign ev[EV_OVF] = wrap && !capture;              // RQ16

    // ================================================================
    // channel next state and counter
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        data_d  = data_q;
        case (state_q)
            ST_IDLE: begin
                if (start_wr) begin
                    state_d = ST_RUN;
                    count_d = COUNT_RST;               // RQ5
                end
            end
            ST_RUN: begin
                if (stop_wr) begin
                    state_d = ST_IDLE;                 // counter holds
                end else if (start_wr) begin
                    count_d = COUNT_RST;               // RQ5
                end else if (capture) begin
                    data_d  = count_q;                 // RQ6
                    count_d = COUNT_RST;               // RQ8
                end else if (tick) begin
                    count_d = count_q + COUNT_W'(1);   // RQ1 RQ16
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ================================================================
    // registers written by software and sticky status
    always_comb begin
        mode_d  = mode_q;
        irqen_d = irqen_q;
        if (reg_wr && reg_addr == OFS_MODE) begin
            mode_d = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == OFS_IRQEN) begin
            irqen_d = reg_wdata[EV_W-1:0];
        end
        // clear by write-one, a new event wins over the clear
        stat_d = stat_q;
        if (reg_wr && reg_addr == OFS_CLR) begin
            stat_d = stat_q & ~reg_wdata[EV_W-1:0];
        end
        stat_d = stat_d | ev;                          // RQ7
    end

    // ================================================================
    // read mux, data stands one cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_MODE:  rdata_d = {24'h000000, mode_q};
                OFS_COUNT: rdata_d = {16'h0000, count_q};
                OFS_DATA:  rdata_d = {16'h0000, data_q};   // RQ6
                OFS_STAT:  rdata_d = {29'h0, (state_q == ST_RUN), stat_q};
                OFS_IRQEN: rdata_d = {30'h0, irqen_q};
                default:   rdata_d = '0;                   // unmapped
            endcase
        end
    end

    // ================================================================
    // state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            count_q <= COUNT_RST;
            data_q  <= COUNT_RST;
            mode_q  <= MODE_RST;
            stat_q  <= EV_RST;
            irqen_q <= EV_RST;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            data_q  <= data_d;
            mode_q  <= mode_d;
            stat_q  <= stat_d;
            irqen_q <= irqen_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign capture_done_irq = |(stat_q & irqen_q);     // RQ7

    // ================================================================
    // assertions
    sequence s_cap;
        capture && !stop_wr && !start_wr;
    endsequence

    AST_CAP_DATA: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        s_cap |=> data_q == $past(count_q))
        else $error("capture data does not match count");
    AST_CAP_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        s_cap |=> count_q == 16'h0000)
        else $error("count not cleared after capture");
    AST_CAP_STAT: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        capture |=> stat_q[EV_CAP])
        else $error("capture status not set");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        (stat_q[EV_CAP] && irqen_q[EV_CAP]) |-> capture_done_irq)
        else $error("interrupt missing for enabled status");
    AST_START: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        (start_wr && !stop_wr) |=> state_q == ST_RUN && count_q == 16'h0000)
        else $error("start did not clear and run");
    AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
        (wrap && !capture && !start_wr && !stop_wr)
            |=> count_q == 16'h0000 && stat_q[EV_OVF])
        else $error("wrap without overflow flag");
    AST_INC: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        (state_q == ST_RUN && tick && !capture && !start_wr && !stop_wr)
            |=> count_q == $past(count_q) + 16'h0001)
        else $error("counter did not increment");
    AST_EDGE_TRIG: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
        (!mode_q[MODE_CAP]) |-> !capture)
        else $error("capture while trigger disabled");
endmodule // pulse_interval_capture_channel

/* testbench/pulse_source.sv */
// model of the external pulse source that drives the timer input pin
`timescale 1ns/1ps
module pulse_source (
    input  wire logic        clk,    // system clock
    input  wire logic        en,     // emit pulses while high
    input  wire logic [15:0] period, // clocks from one rising edge to the next
    output logic             pin     // pulse output
);
    logic [15:0] cnt_q; // position inside the period
    initial begin
        pin = 1'b0;
        cnt_q = 16'h0000;
    end
    // ================================================================
    // pulse generation
    // high for the first half of each period, so every level lasts far over two clocks
    always @(posedge clk) begin
        if (!en || cnt_q >= period - 16'h0001)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_q + 16'h0001;
        pin <= en && (cnt_q < (period >> 1));
    end
endmodule // pulse_source

/* testbench/test_pulse_interval_capture_channel.sv */
// self-checking bench of the capture channel acting as interrupt-driven firmware
`timescale 1ns/1ps
module test_pulse_interval_capture_channel;
    import capture_pkg::*;
    logic              clk, rst_n, pin, reg_wr, reg_rd, irq, src_en, first;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_v;
    logic [15:0]       interval_result_array [8]; // stored intervals
    int                remaining_attempts_count, miscompares, cmp_count, cycles;
    logic [ADDR_W-1:0] ra [6]; // registers read at reset
    // ================================================================
    // design and pulse source
    pulse_interval_capture_channel dut_u (.clk(clk), .rst_n(rst_n), .pulse_input_pin(pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .capture_done_irq(irq));
    pulse_source src_u (.clk(clk), .en(src_en), .period(16'h0040), .pin(pin));
    always #10 clk = ~clk;
    // ================================================================
    // tasks
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task in_range(input logic [DATA_W-1:0] v, input int lo, input int hi);
        check({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // bounded wait for the interrupt line to reach a level
    task wait_irq(input logic v, input int n);
        for (int i = 0; i < n && irq !== v; i++)
            @(posedge clk);
        #1 check({31'h0, irq}, {31'h0, v});
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ================================================================
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end
    // ================================================================
    // main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; src_en = 1'b0;
        reg_addr = 4'h0; reg_wdata = 32'h0; first = 1'b1;
        ra = '{OFS_STAT, OFS_MODE, OFS_IRQEN, OFS_COUNT, OFS_DATA, 4'h5};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // idle registers and an unmapped place read zero
        foreach (ra[i]) begin
            rd(ra[i], rd_v);
            check(rd_v, 32'h0);
        end
        $display("test reset values done");
        wr(OFS_MODE, 32'h23);
        wr(OFS_START, 32'h1);
        repeat (100) @(posedge clk);
        rd(OFS_COUNT, rd_v);
        in_range(rd_v, 23, 27);
        wr(OFS_START, 32'h1);
        rd(OFS_COUNT, rd_v);
        check(rd_v, 32'h0);
        wr(OFS_START, 32'h2);
        $display("test start and count done");
        wr(OFS_IRQEN, 32'h1);
        wr(OFS_START, 32'h1);
        src_en <= 1'b1;
        remaining_attempts_count = 8;
        while (remaining_attempts_count > 0) begin
            wait_irq(1'b1, 200);
            rd(OFS_DATA, rd_v);
            wr(OFS_CLR, 32'h1);
            #1 check({31'h0, irq}, 32'h0);
            // the first value does not span a whole interval
            if (first)
                first = 1'b0;
            else begin
                in_range(rd_v, 15, 16);
                in_range(rd_v, 6, 65535);
                interval_result_array[8 - remaining_attempts_count] = rd_v[15:0];
                remaining_attempts_count--;
            end
        end
        $display("test interval capture done");
        wr(OFS_MODE, 32'h22);
        wr(OFS_CLR, 32'h3);
        repeat (300) @(posedge clk);
        rd(OFS_STAT, rd_v);
        check({30'h0, rd_v[1:0]}, 32'h0);
        $display("test capture disabled done");
        // falling edge selected as the valid edge
        wr(OFS_MODE, 32'h21);
        wait_irq(1'b1, 200);
        $display("test falling edge done");
        src_en <= 1'b0;
        wr(OFS_MODE, 32'h03);
        wr(OFS_IRQEN, 32'h2);
        wr(OFS_START, 32'h1);
        wr(OFS_CLR, 32'h3);
        wait_irq(1'b1, 66000);
        rd(OFS_STAT, rd_v);
        check({30'h0, rd_v[1:0]}, 32'h2);
        // an overflowed interval is stored as zero
        interval_result_array[0] = rd_v[1] ? 16'h0000 : 16'hFFFF;
        check({16'h0000, interval_result_array[0]}, 32'h0);
        wr(OFS_IRQEN, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        wr(OFS_CLR, 32'h2);
        rd(OFS_STAT, rd_v);
        check({30'h0, rd_v[1:0]}, 32'h0);
        $display("test overflow done");
        summarize();
    end
endmodule // test_pulse_interval_capture_channel
